// ==== core/tmp_ctrl.sv ====
// How it works
// - four modes: normal, one-shot, one-per-second, shutdown
// - normal mode converts back to back, 240 ms
// - every finished result lands in temperature registers
// - first conversion after reset is fast, 6 ms
// - fast result above 147 C trips critical alert
// - fast result above 64 C trips limit alert
// - conversions timed internally; serial clock only for access
// - limit alert when above high or below low
// - critical alert when above critical setpoint
// - configuration bits set both alert polarities
// - configuration bit picks interrupt or comparator behaviour
// - reset: both alerts active low, comparator
// - mode bits 0 then 1 select one-shot
// - one-shot converts once then shuts down
// - each one-shot write starts a new conversion
// - two strap inputs form low address bits
// - one-per-second: 60 ms conversion, idle rest
// - shutdown stops conversions; normal write restarts them
// - interrupt mode: any register read clears alerts
`default_nettype none
module tmp_ctrl #(
   parameter int FAST_CONV_US = tmp_pkg::FAST_CONV_MS * tmp_pkg::US_PER_MS,
   parameter int NORMAL_CONV_US = tmp_pkg::NORMAL_CONV_MS * tmp_pkg::US_PER_MS,
   parameter int SPS_CONV_US = tmp_pkg::SPS_CONV_MS * tmp_pkg::US_PER_MS,
   parameter int SPS_IDLE_US = (tmp_pkg::SPS_PERIOD_MS - tmp_pkg::SPS_CONV_MS)
                               * tmp_pkg::US_PER_MS,
   // arbitrary value
   parameter logic [7:0] ID_CODE = 8'h5A
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // sensor front end
   input wire logic [15:0] temp_code,
   // serial port
   input wire logic scl,
   input wire logic sda_in,
   output tmp_pkg::tmp_od_t sda_pad,
   input wire logic bus_addr_sel_lo,
   input wire logic bus_addr_sel_hi,
   // alert pins
   output tmp_pkg::tmp_od_t critical_alert_out,
   output tmp_pkg::tmp_od_t limit_alert_out
);
   import tmp_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic tick;
   tmp_cv_t cv_ff, nxt_cv;
   logic [TMR_W-1:0] tmr_ff, nxt_tmr;
   logic conv_done;
   tmp_cfg_t cfg_ff, nxt_cfg;
   logic [15:0] temp_ff, nxt_temp, high_ff, nxt_high, low_ff, nxt_low, crit_ff, nxt_crit;
   tmp_cmp_t cmp_ff, nxt_cmp;
   logic lim_act_ff, nxt_lim_act, crit_act_ff, nxt_crit_act;
   tmp_od_t lim_pin_ff, nxt_lim_pin, crit_pin_ff, nxt_crit_pin, sda_ff, nxt_sda;
   tmp_i2_t i2_ff, nxt_i2;
   logic [3:0] bit_ff, nxt_bit;
   logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr;
   logic rw_ff, nxt_rw, first_ff, nxt_first, nack_ff, nxt_nack;
   logic scl_q_ff, sda_q_ff;
   logic [1:0] sel_ff, nxt_sel;
   logic sel_ok_ff;
   logic wr_stb, rd_stb, cfg_wr;
   logic c_crit, c_high, c_low;
   tmp_cfg_t wr_cfg;
   logic [7:0] rd_data;

   // internal time base, independent of the serial clock
   tmp_tick #(
      .DIV(TICK_CYC)
   ) u_tick (
      .mclk(mclk),
      .reset(reset),
      .tick(tick)
   );

   function automatic logic [TMR_W-1:0] conv_len(input tmp_mode_t m);
      conv_len = (m == MODE_ONE_SPS) ? TMR_W'(SPS_CONV_US - 1)
                                     : TMR_W'(NORMAL_CONV_US - 1);
   endfunction

   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      tmp_stat_t st;
      st = '{busy: (cv_ff == CV_FAST) || (cv_ff == CV_CONV), cmp: cmp_ff, rsvd: 4'h0};
      case (a)
         REG_TEMP_MSB: rd_byte = temp_ff[15:8];
         REG_TEMP_LSB: rd_byte = temp_ff[7:0];
         REG_STATUS: rd_byte = st;
         REG_CFG: rd_byte = cfg_ff;
         REG_HIGH_MSB: rd_byte = high_ff[15:8];
         REG_HIGH_LSB: rd_byte = high_ff[7:0];
         REG_LOW_MSB: rd_byte = low_ff[15:8];
         REG_LOW_LSB: rd_byte = low_ff[7:0];
         REG_CRIT_MSB: rd_byte = crit_ff[15:8];
         REG_CRIT_LSB: rd_byte = crit_ff[7:0];
         REG_ID: rd_byte = ID_CODE;
         default: rd_byte = BYTE_ZERO;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // serial port slave
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_i2 = i2_ff;
      nxt_bit = bit_ff;
      nxt_sh = sh_ff;
      nxt_ptr = ptr_ff;
      nxt_rw = rw_ff;
      nxt_first = first_ff;
      nxt_nack = nack_ff;
      nxt_sda = sda_ff;
      nxt_sel = sel_ok_ff ? sel_ff : {bus_addr_sel_hi, bus_addr_sel_lo};
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      rd_data = rd_byte(ptr_ff);
      if (scl && scl_q_ff && !sda_q_ff && sda_in)
      begin
         nxt_i2 = I2_IDLE;
         nxt_sda.oe_n = 1'b1;
      end
      else if (scl && scl_q_ff && sda_q_ff && !sda_in)
      begin
         nxt_i2 = I2_ADDR;
         nxt_bit = BIT_ZERO;
         nxt_sda.oe_n = 1'b1;
      end
      else
      begin
         case (i2_ff)
            I2_ADDR, I2_WR:
            begin
               if (scl && !scl_q_ff)
               begin
                  nxt_sh = {sh_ff[6:0], sda_in};
                  nxt_bit = bit_ff + BIT_ONE;
               end
               else if (!scl && scl_q_ff && bit_ff == BITS_PER_BYTE)
               begin
                  if (i2_ff == I2_ADDR)
                  begin
                     if (sh_ff[7:1] == {ADDR_BASE, sel_ff})
                     begin
                        nxt_i2 = I2_AACK;
                        nxt_rw = sh_ff[0];
                        nxt_first = 1'b1;
                        nxt_sda.oe_n = 1'b0;
                     end
                     else
                        nxt_i2 = I2_IDLE;
                  end
                  else
                  begin
                     // first data byte after the address sets the pointer
                     wr_stb = !first_ff;
                     nxt_ptr = first_ff ? sh_ff : ptr_ff + PTR_ONE;
                     nxt_first = 1'b0;
                     nxt_i2 = I2_WACK;
                     nxt_sda.oe_n = 1'b0;
                  end
               end
            end
            I2_AACK, I2_RACK:
            begin
               if (scl && !scl_q_ff && i2_ff == I2_RACK)
                  nxt_nack = sda_in;
               else if (!scl && scl_q_ff)
               begin
                  if (i2_ff == I2_AACK && !rw_ff)
                  begin
                     nxt_i2 = I2_WR;
                     nxt_bit = BIT_ZERO;
                     nxt_sda.oe_n = 1'b1;
                  end
                  else if (i2_ff == I2_RACK && nack_ff)
                  begin
                     nxt_i2 = I2_IDLE;
                     nxt_sda.oe_n = 1'b1;
                  end
                  else
                  begin
                     rd_stb = 1'b1;
                     nxt_sh = rd_data;
                     nxt_ptr = ptr_ff + PTR_ONE;
                     nxt_sda.oe_n = rd_data[7];
                     nxt_bit = BIT_ONE;
                     nxt_i2 = I2_RD;
                  end
               end
            end
            I2_WACK:
            begin
               if (!scl && scl_q_ff)
               begin
                  nxt_i2 = I2_WR;
                  nxt_bit = BIT_ZERO;
                  nxt_sda.oe_n = 1'b1;
               end
            end
            I2_RD:
            begin
               if (!scl && scl_q_ff)
               begin
                  if (bit_ff == BITS_PER_BYTE)
                  begin
                     nxt_i2 = I2_RACK;
                     nxt_sda.oe_n = 1'b1;
                  end
                  else
                  begin
                     nxt_sda.oe_n = sh_ff[6];
                     nxt_sh = {sh_ff[6:0], 1'b0};
                     nxt_bit = bit_ff + BIT_ONE;
                  end
               end
            end
            I2_IDLE: ;
            default: nxt_i2 = I2_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         i2_ff <= I2_IDLE;
         bit_ff <= BIT_ZERO;
         sh_ff <= BYTE_ZERO;
         ptr_ff <= REG_TEMP_MSB;
         rw_ff <= 1'b0;
         first_ff <= 1'b0;
         nack_ff <= 1'b0;
         sda_ff <= '{out: 1'b0, oe_n: 1'b1};
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         sel_ff <= 2'h0;
         sel_ok_ff <= 1'b0;
      end
      else
      begin
         i2_ff <= nxt_i2;
         bit_ff <= nxt_bit;
         sh_ff <= nxt_sh;
         ptr_ff <= nxt_ptr;
         rw_ff <= nxt_rw;
         first_ff <= nxt_first;
         nack_ff <= nxt_nack;
         sda_ff <= nxt_sda;
         scl_q_ff <= scl;
         sda_q_ff <= sda_in;
         sel_ff <= nxt_sel;
         sel_ok_ff <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // conversion sequencer
   // ---------------------------------------------------------------
   assign wr_cfg = sh_ff;
   assign cfg_wr = wr_stb && ptr_ff == REG_CFG;

   always_comb
   begin
      nxt_cv = cv_ff;
      nxt_tmr = tmr_ff;
      conv_done = tick && tmr_ff == TMR_ZERO && (cv_ff == CV_FAST || cv_ff == CV_CONV);
      if (tick && tmr_ff != TMR_ZERO && cv_ff != CV_SHUT)
         nxt_tmr = tmr_ff - TMR_ONE;
      case (cv_ff)
         CV_FAST:
         begin
            if (conv_done)
            begin
               nxt_cv = (cfg_ff.op_mode == MODE_SHUTDOWN) ? CV_SHUT : CV_CONV;
               nxt_tmr = conv_len(cfg_ff.op_mode);
            end
         end
         CV_CONV:
         begin
            if (conv_done)
            begin
               case (cfg_ff.op_mode)
                  MODE_NORMAL: nxt_tmr = conv_len(MODE_NORMAL);
                  MODE_ONE_SHOT: nxt_cv = CV_SHUT;
                  MODE_ONE_SPS:
                  begin
                     nxt_cv = CV_IDLE;
                     nxt_tmr = TMR_W'(SPS_IDLE_US - 1);
                  end
                  default: nxt_cv = CV_SHUT;
               endcase
            end
         end
         CV_IDLE:
         begin
            if (tick && tmr_ff == TMR_ZERO)
            begin
               nxt_cv = CV_CONV;
               nxt_tmr = conv_len(MODE_ONE_SPS);
            end
         end
         CV_SHUT: ;
         default: nxt_cv = CV_SHUT;
      endcase
      // a shutdown, one-shot or changed-mode write, or any mode write while shut down, overrides the sequencer
      if (cfg_wr)
      begin
         if (wr_cfg.op_mode == MODE_SHUTDOWN)
            nxt_cv = CV_SHUT;
         else if (wr_cfg.op_mode == MODE_ONE_SHOT || cv_ff == CV_SHUT
                  || wr_cfg.op_mode != cfg_ff.op_mode)
         begin
            nxt_cv = CV_CONV;
            nxt_tmr = conv_len(wr_cfg.op_mode);
         end
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cv_ff <= CV_FAST;
         tmr_ff <= TMR_W'(FAST_CONV_US - 1);
      end
      else
      begin
         cv_ff <= nxt_cv;
         tmr_ff <= nxt_tmr;
      end
   end

   // ---------------------------------------------------------------
   // registers and alerts
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_cfg = cfg_ff;
      nxt_high = high_ff;
      nxt_low = low_ff;
      nxt_crit = crit_ff;
      nxt_temp = temp_ff;
      nxt_cmp = cmp_ff;
      nxt_lim_act = lim_act_ff;
      nxt_crit_act = crit_act_ff;
      if (wr_stb)
      begin
         case (ptr_ff)
            REG_CFG: nxt_cfg = wr_cfg;
            REG_HIGH_MSB: nxt_high[15:8] = sh_ff;
            REG_HIGH_LSB: nxt_high[7:0] = sh_ff;
            REG_LOW_MSB: nxt_low[15:8] = sh_ff;
            REG_LOW_LSB: nxt_low[7:0] = sh_ff;
            REG_CRIT_MSB: nxt_crit[15:8] = sh_ff;
            REG_CRIT_LSB: nxt_crit[7:0] = sh_ff;
            default: ;
         endcase
      end
      // fast result uses fixed trip points, not the setpoints
      if (cv_ff == CV_FAST)
      begin
         c_crit = $signed(temp_code) > $signed(FAST_CRIT_LIM);
         c_high = $signed(temp_code) > $signed(FAST_LIMIT_LIM);
         c_low = 1'b0;
      end
      else
      begin
         c_crit = $signed(temp_code) > $signed(crit_ff);
         c_high = $signed(temp_code) > $signed(high_ff);
         c_low = $signed(temp_code) < $signed(low_ff);
      end
      if (conv_done)
      begin
         nxt_temp = temp_code;
         nxt_cmp = '{crit: c_crit, high: c_high, low: c_low};
      end
      if (cfg_ff.int_mode)
      begin
         // a read clears, a finishing conversion sets; set wins
         if (rd_stb)
         begin
            nxt_lim_act = 1'b0;
            nxt_crit_act = 1'b0;
         end
         if (conv_done && (c_high || c_low))
            nxt_lim_act = 1'b1;
         if (conv_done && c_crit)
            nxt_crit_act = 1'b1;
      end
      else if (conv_done)
      begin
         nxt_lim_act = c_high || c_low;
         nxt_crit_act = c_crit;
      end
      nxt_lim_pin = '{out: 1'b0, oe_n: !(lim_act_ff ^ cfg_ff.limit_pol)};
      nxt_crit_pin = '{out: 1'b0, oe_n: !(crit_act_ff ^ cfg_ff.crit_pol)};
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cfg_ff <= CFG_RST;
         high_ff <= HIGH_RST;
         low_ff <= LOW_RST;
         crit_ff <= CRIT_RST;
         temp_ff <= TEMP_RST;
         cmp_ff <= '{crit: 1'b0, high: 1'b0, low: 1'b0};
         lim_act_ff <= 1'b0;
         crit_act_ff <= 1'b0;
         lim_pin_ff <= '{out: 1'b0, oe_n: 1'b1};
         crit_pin_ff <= '{out: 1'b0, oe_n: 1'b1};
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         high_ff <= nxt_high;
         low_ff <= nxt_low;
         crit_ff <= nxt_crit;
         temp_ff <= nxt_temp;
         cmp_ff <= nxt_cmp;
         lim_act_ff <= nxt_lim_act;
         crit_act_ff <= nxt_crit_act;
         lim_pin_ff <= nxt_lim_pin;
         crit_pin_ff <= nxt_crit_pin;
      end
   end

   assign sda_pad = sda_ff;
   assign limit_alert_out = lim_pin_ff;
   assign critical_alert_out = crit_pin_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_oneshot_req;
      cfg_wr && wr_cfg.op_mode == MODE_ONE_SHOT;
   endsequence

   sequence s_fast_done;
      conv_done && cv_ff == CV_FAST;
   endsequence

   chk_shut_idle: assert property (
      cv_ff == CV_SHUT && !cfg_wr |=> cv_ff == CV_SHUT && $stable(temp_ff))
      else $error("shutdown left or result changed");
   chk_oneshot_start: assert property (s_oneshot_req |=> cv_ff == CV_CONV)
      else $error("one-shot write did not start a conversion");
   chk_oneshot_stop: assert property (
      conv_done && cv_ff == CV_CONV && !cfg_wr && cfg_ff.op_mode == MODE_ONE_SHOT
      |=> cv_ff == CV_SHUT)
      else $error("one-shot did not shut down after its conversion");
   chk_normal_loop: assert property (
      conv_done && cv_ff == CV_CONV && !cfg_wr && cfg_ff.op_mode == MODE_NORMAL
      |=> cv_ff == CV_CONV && tmr_ff == TMR_W'(NORMAL_CONV_US - 1))
      else $error("normal mode did not restart conversion");
   chk_result_store: assert property (conv_done |=> temp_ff == $past(temp_code))
      else $error("result not stored");
   chk_fast_crit: assert property (
      s_fast_done and $signed(temp_code) > $signed(FAST_CRIT_LIM) |=> crit_act_ff)
      else $error("fast over-critical not flagged");
   chk_fast_limit: assert property (
      s_fast_done and !cfg_ff.int_mode
      |=> lim_act_ff == ($signed($past(temp_code)) > $signed(FAST_LIMIT_LIM)))
      else $error("fast limit flag wrong");
   chk_alert_hold: assert property (
      !conv_done && !rd_stb |=> $stable(lim_act_ff) && $stable(crit_act_ff))
      else $error("alert moved without a conversion");
   chk_pin_level: assert property (
      ##1 lim_pin_ff.oe_n == !($past(lim_act_ff) ^ $past(cfg_ff.limit_pol)))
      else $error("limit pin level wrong");
   chk_read_clear: assert property (
      cfg_ff.int_mode && rd_stb && !conv_done |=> !lim_act_ff && !crit_act_ff)
      else $error("read did not clear alerts");
endmodule
`default_nettype wire

// ==== core/tmp_pkg.sv ====
`default_nettype none
package tmp_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int US_PER_MS = 1000;
   localparam int FAST_CONV_MS = 6;
   localparam int NORMAL_CONV_MS = 240;
   localparam int SPS_CONV_MS = 60;
   localparam int SPS_PERIOD_MS = 1000;
   localparam int TMR_W = 20;
   localparam int TICK_W = 12;
   localparam logic [TMR_W-1:0] TMR_ZERO = 20'h00000;
   localparam logic [TMR_W-1:0] TMR_ONE = 20'h00001;
   localparam logic [TICK_W-1:0] TICK_ZERO = 12'h000;
   localparam logic [TICK_W-1:0] TICK_ONE = 12'h001;

   // ---------------------------------------------------------------
   // register map and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_TEMP_MSB = 8'h00;
   localparam logic [7:0] REG_TEMP_LSB = 8'h01;
   localparam logic [7:0] REG_STATUS = 8'h02;
   localparam logic [7:0] REG_CFG = 8'h03;
   localparam logic [7:0] REG_HIGH_MSB = 8'h04;
   localparam logic [7:0] REG_HIGH_LSB = 8'h05;
   localparam logic [7:0] REG_LOW_MSB = 8'h06;
   localparam logic [7:0] REG_LOW_LSB = 8'h07;
   localparam logic [7:0] REG_CRIT_MSB = 8'h08;
   localparam logic [7:0] REG_CRIT_LSB = 8'h09;
   localparam logic [7:0] REG_ID = 8'h0B;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [15:0] HIGH_RST = 16'h2000;
   localparam logic [15:0] LOW_RST = 16'h0A00;
   localparam logic [15:0] CRIT_RST = 16'h4980;
   localparam logic [15:0] TEMP_RST = 16'h0000;
   localparam logic [15:0] FAST_CRIT_LIM = 16'h4980;
   localparam logic [15:0] FAST_LIMIT_LIM = 16'h2000;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] PTR_ONE = 8'h01;

   // ---------------------------------------------------------------
   // serial port
   // ---------------------------------------------------------------
   localparam logic [4:0] ADDR_BASE = 5'h12;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'h0,
      MODE_ONE_SHOT = 2'h1,
      MODE_ONE_SPS = 2'h2,
      MODE_SHUTDOWN = 2'h3
   } tmp_mode_t;

   typedef struct packed
   {
      logic res_16;
      tmp_mode_t op_mode;
      logic int_mode;
      logic limit_pol;
      logic crit_pol;
      logic [1:0] fault_q;
   } tmp_cfg_t;

   typedef struct packed
   {
      logic crit;
      logic high;
      logic low;
   } tmp_cmp_t;

   typedef struct packed
   {
      logic busy;
      tmp_cmp_t cmp;
      logic [3:0] rsvd;
   } tmp_stat_t;

   typedef struct packed
   {
      logic out;
      logic oe_n;
   } tmp_od_t;

   typedef enum logic [1:0]
   {
      CV_FAST = 2'h0,
      CV_CONV = 2'h1,
      CV_IDLE = 2'h3,
      CV_SHUT = 2'h2
   } tmp_cv_t;

   typedef enum logic [2:0]
   {
      I2_IDLE = 3'h0,
      I2_ADDR = 3'h1,
      I2_AACK = 3'h3,
      I2_WR = 3'h2,
      I2_WACK = 3'h6,
      I2_RD = 3'h7,
      I2_RACK = 3'h5
   } tmp_i2_t;
endpackage
`default_nettype wire

// ==== core/tmp_tick.sv ====
`default_nettype none
module tmp_tick #(
   parameter int DIV = 100
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // one-cycle enable
   output logic tick
);
   import tmp_pkg::*;

   logic [TICK_W-1:0] cnt_ff;
   logic [TICK_W-1:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;

   always_comb
   begin
      nxt_tick = (cnt_ff == TICK_W'(DIV - 1));
      nxt_cnt = nxt_tick ? TICK_ZERO : cnt_ff + TICK_ONE;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cnt_ff <= TICK_ZERO;
         tick_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule
`default_nettype wire

// ==== test/temp_conversion_mode_alert_ctrl_bench.sv ====
`default_nettype none
module temp_conversion_mode_alert_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import tmp_pkg::*;
   logic mclk, reset, scl, sda_in, sel_lo, sel_hi, rd_valid;
   logic [15:0] temp_code, last;
   logic [7:0] rd_data, nacks;
   logic [6:0] dev;
   tmp_od_t sda_pad, crit_pin, lim_pin;
   logic [7:0] exp_q[$];
   logic [7:0] modes[5] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h40};
   int bad_count, comparisons;
   // ---------------------------------------------------------------
   // short conversion counts keep the run small
   // ---------------------------------------------------------------
   tmp_ctrl #(.FAST_CONV_US(3), .NORMAL_CONV_US(8), .SPS_CONV_US(4), .SPS_IDLE_US(6)) i_dut (
      .mclk(mclk), .reset(reset), .temp_code(temp_code), .scl(scl), .sda_in(sda_in),
      .sda_pad(sda_pad), .bus_addr_sel_lo(sel_lo), .bus_addr_sel_hi(sel_hi),
      .critical_alert_out(crit_pin), .limit_alert_out(lim_pin));
   tmp_host i_host (.mclk(mclk), .sda_pad(sda_pad), .scl(scl), .sda_in(sda_in),
      .rd_valid(rd_valid), .rd_data(rd_data), .nack_count(nacks));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.reg_rd(dev, p);
   endtask
   task automatic pins(input logic c, input logic l, input int wait_cyc);
      repeat (wait_cyc) @(negedge mclk);
      check({6'h00, crit_pin}, {7'h00, c});
      check({6'h00, lim_pin}, {7'h00, l});
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
      if (rd_valid && exp_q.size() > 0)
         check(rd_data, exp_q.pop_front());
   initial
   begin
      repeat (90000) @(posedge mclk);
      bad_count++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(32'h6a8a));
      reset = 1'b1;
      temp_code = 16'h4A00;
      {sel_hi, sel_lo} = 2'($urandom);
      dev = {ADDR_BASE, sel_hi, sel_lo};
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      pins(1'b0, 1'b0, 450);
      rd(REG_CFG, CFG_RST);
      foreach (modes[k])
      begin
         last = 16'h1000 | 16'($urandom_range(0, 16'h0FFF));
         temp_code = last;
         i_host.reg_wr(dev, REG_CFG, modes[k]);
         repeat (1100) @(negedge mclk);
         rd(REG_TEMP_MSB, last[15:8]);
         rd(REG_TEMP_LSB, last[7:0]);
      end
      pins(1'b1, 1'b1, 1);
      i_host.reg_wr(dev, REG_CFG, 8'h60);
      temp_code = 16'h4A00;
      pins(1'b1, 1'b1, 1100);
      rd(REG_TEMP_MSB, last[15:8]);
      // interrupt mode: a read drops both alerts
      i_host.reg_wr(dev, REG_CFG, 8'h30);
      pins(1'b0, 1'b0, 1100);
      rd(REG_STATUS, 8'h60);
      pins(1'b1, 1'b1, 5);
      // active-high, value below the low limit
      temp_code = 16'h0100;
      i_host.reg_wr(dev, REG_CFG, 8'h2C);
      pins(1'b0, 1'b1, 1100);
      // second reset, cold: fast result never trips the low side
      temp_code = 16'h0100;
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      pins(1'b1, 1'b1, 450);
      pins(1'b1, 1'b0, 800);
      rd(REG_CFG, CFG_RST);
      // lowered high setpoint makes a mid-range value trip
      temp_code = 16'h1100;
      i_host.reg_wr(dev, REG_HIGH_MSB, 8'h10);
      rd(REG_HIGH_MSB, 8'h10);
      pins(1'b1, 1'b0, 1);
      for (int m = 0; m < 4; m++)
      begin
         i_host.reg_wr(dev, REG_CFG, {1'b0, 2'(m), 5'h00});
         rd(REG_CFG, {1'b0, 2'(m), 5'h00});
      end
      check(nacks, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire

// ==== test/tmp_host.sv ====
`default_nettype none
module tmp_host (
   // clock and bus pins
   input wire logic mclk,
   input wire tmp_pkg::tmp_od_t sda_pad,
   output logic scl,
   output logic sda_in,
   // read results and nack count
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic [7:0] nack_count
);
   timeunit 1ns;
   timeprecision 100ps;
   import tmp_pkg::*;
   logic drv;
   // pull-up: low only while someone pulls
   assign sda_in = drv & sda_pad.oe_n;
   initial
   begin
      scl = 1'b1;
      drv = 1'b1;
      rd_valid = 1'b0;
      rd_data = 8'h00;
      nack_count = 8'h00;
   end
   task automatic half();
      repeat (20) @(negedge mclk);
   endtask
   task automatic clk_bit(input logic b, output logic s);
      drv = b;
      half();
      scl = 1'b1;
      half();
      s = sda_in;
      scl = 1'b0;
   endtask
   task automatic start();
      drv = 1'b1;
      half();
      scl = 1'b1;
      half();
      drv = 1'b0;
      half();
      scl = 1'b0;
   endtask
   task automatic stop();
      drv = 1'b0;
      half();
      scl = 1'b1;
      half();
      drv = 1'b1;
      half();
   endtask
   task automatic send(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(d[i], s);
      clk_bit(1'b1, s);
      if (s)
         nack_count++;
   endtask
   task automatic reg_wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
      start();
      send({a, 1'b0});
      send(p);
      send(d);
      stop();
   endtask
   task automatic reg_rd(input logic [6:0] a, input logic [7:0] p);
      logic [7:0] v;
      logic s;
      start();
      send({a, 1'b0});
      send(p);
      start();
      send({a, 1'b1});
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, v[i]);
      // master nack ends the read
      clk_bit(1'b1, s);
      stop();
      rd_data = v;
      rd_valid = 1'b1;
      @(negedge mclk);
      rd_valid = 1'b0;
   endtask
endmodule
`default_nettype wire
